// *** hcc_cfg.svh ***
/*
 * constants of the halt clock controller: register offsets, field positions,
 * reset values and sequence counts.
 * assumes it is included once per compilation unit by its bare name.
 */
`ifndef HCC_CFG_SVH
`define HCC_CFG_SVH

// register byte offsets
`define HCC_CTRL_OFFSET 4'h0
`define HCC_STATUS_OFFSET 4'h4

// control register field positions
`define HCC_CTRL_DIV_BIT 0
`define HCC_CTRL_MS1_BIT 1
`define HCC_CTRL_MS2_BIT 2
`define HCC_CTRL_WSEL_BIT 3

// control reset values: full rate, run mode, long warm-up
`define HCC_CTRL_DIV_RESET 1'b1
`define HCC_CTRL_MS1_RESET 1'b1
`define HCC_CTRL_MS2_RESET 1'b1
`define HCC_CTRL_WSEL_RESET 1'b0

// clk_in cycles per oscillator half period, default
`define HCC_OSC_HALF_DEFAULT 2
// warm-up length as log2 of oscillator periods
`define HCC_WARM_LONG_LOG2 17
`define HCC_WARM_SHORT_LOG2 14
// oscillator half periods waited on an idle restart
`define HCC_RESUME_TICKS 4'h5
// generated clock rising edges for which the reset fan-out stays low
`define HCC_RESET_HOLD 2'h3

// axi response codes
`define HCC_RESP_OKAY 2'h0
`define HCC_RESP_SLVERR 2'h2

`endif

// *** hcc_pkg.sv ***
/*
 * types of the halt clock controller: sequencer states and the packed
 * state record of the top module.
 * assumes hcc_cfg.svh is on the include path.
 */
package hcc_pkg;
    // clock sequencer states, one-hot
    typedef enum logic [4:0] {
        HCC_S_RUN = 5'h01, // clock running
        HCC_S_IDLE = 5'h02, // halted, oscillator running
        HCC_S_STOP = 5'h04, // halted, oscillator frozen
        HCC_S_WARM = 5'h08, // warm-up counting after a stop
        HCC_S_RESUME = 5'h10 // short delay after an idle restart
    } hcc_state_type;

    // every flip-flop of the top module
    typedef struct packed {
        hcc_state_type st;
        logic [7:0] div; // oscillator half-period divider
        logic phase; // half-rate toggle phase
        logic clk; // generated clock
        logic halt_arm; // halt seen, waiting for the low phase
        logic edge_pend; // latched edge restart
        logic [18:0] warm; // warm-up counter in half periods
        logic [3:0] resume; // idle restart delay
        logic [1:0] rfo_cnt; // reset fan-out stretch
        logic rfo; // reset fan-out, active low
        logic echo; // edge restart echo, active low
        logic [2:0] halt_s; // halted synchroniser + edge stage
        logic [1:0] m1_s; // opcode fetch synchroniser
        logic [1:0] lvl_s; // level restart synchroniser
        logic [2:0] edg_s; // edge restart synchroniser + edge stage
        logic [1:0] rst_s; // reset pin synchroniser
        logic div_sel; // control: full rate when high
        logic ms1; // control: mode select 1
        logic ms2; // control: mode select 2
        logic wsel; // control: short warm-up when high
        logic aw_got;
        logic [3:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } hcc_regs_type;
endpackage

// *** hcc_halt_clock_ctrl.sv ***
/*
 * halt clock controller: makes the processor clock from an oscillator
 * modelled as a one-cycle enable, stops it on halt in idle or stop mode,
 * restarts it on restart or reset pins, with warm-up after a stop unless the reset pin restarts it.
 * assumes clk_in is the only clock; all pins from the processor side are
 * asynchronous and are synchronised here; software sets modes over axi4-lite.
 */
// Overview of operation
// - divide select high: clock equals oscillator rate
// - divide select low: clock is half rate
// - run mode keeps clock going during halt
// - idle mode: oscillator runs, clock held low
// - stop mode: oscillator stops, clock held low
// - outside halt the clock always runs
// - stop clock low at T4 after halt
// - level, edge or reset low restarts clock
// - idle restart resumes after short delay
// - stop restart by pins runs warm-up first
// - warm-up 2^17 or 2^14 oscillator periods
// - reset restart skips the warm-up
// - edge restart passes to echo output
// - reset output feeds processor and peripherals
`include "hcc_cfg.svh"

module hcc_halt_clock_ctrl
    import hcc_pkg::*;
#(
    parameter int OSC_HALF = `HCC_OSC_HALF_DEFAULT, // clk_in cycles per oscillator half period
    parameter int WARM_LONG_LOG2 = `HCC_WARM_LONG_LOG2, // warm-up log2 with select low
    parameter int WARM_SHORT_LOG2 = `HCC_WARM_SHORT_LOG2 // warm-up log2 with select high
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // processor side pins
    input wire logic halted_in_n,
    input wire logic opcode_fetch_cycle_in_n,
    input wire logic restart_level_in_n,
    input wire logic restart_edge_in_n,
    input wire logic system_reset_in_n,
    output logic clk_gen_out,
    output logic restart_echo_out_n,
    output logic reset_fanout_out_n,
    // axi4-lite write channels
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read channels
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // the divider and counter widths are fixed by the state record
    if (OSC_HALF < 1 || OSC_HALF > 256) begin : g_osc_range
        $error("OSC_HALF out of range");
    end
    if (WARM_LONG_LOG2 < 1 || WARM_LONG_LOG2 > 17 || WARM_SHORT_LOG2 < 1 || WARM_SHORT_LOG2 > 17) begin : g_warm_range
        $error("warm-up length out of range");
    end

    // warm-up end in oscillator half periods, minus one
    function automatic logic [18:0] warm_last(input logic sel);
        logic [18:0] n;
        n = sel ? (19'h1 << (WARM_SHORT_LOG2 + 1)) : (19'h1 << (WARM_LONG_LOG2 + 1));
        return n - 19'h1;
    endfunction

    hcc_regs_type q, d;
    logic tick; // one oscillator half period elapsed
    logic osc_on; // oscillator running
    logic stop_mode; // idle or stop selected
    logic restart_req; // any restart condition
    logic edge_fall; // falling edge on the edge restart pin
    logic toggle; // generated clock would change on this tick
    logic aw_now;
    logic w_now;
    logic ar_now;

    // glue decoded from the state record
    always_comb begin
        osc_on = (q.st != HCC_S_STOP);
        tick = osc_on && (q.div == 8'(OSC_HALF - 1));
        stop_mode = !q.ms1 || !q.ms2;
        edge_fall = q.edg_s[2] && !q.edg_s[1];
        restart_req = !q.lvl_s[1] || q.edge_pend || !q.rst_s[1];
        toggle = q.div_sel || q.phase;
        aw_now = s_axi_awvalid && q.awready;
        w_now = s_axi_wvalid && q.wready;
        ar_now = s_axi_arvalid && q.arready;
    end

    // next state of everything
    always_comb begin
        d = q;
        // synchronisers: stage 0 only feeds stage 1
        d.halt_s = {q.halt_s[1:0], halted_in_n};
        d.m1_s = {q.m1_s[0], opcode_fetch_cycle_in_n};
        d.lvl_s = {q.lvl_s[0], restart_level_in_n};
        d.edg_s = {q.edg_s[1:0], restart_edge_in_n};
        d.rst_s = {q.rst_s[0], system_reset_in_n};
        d.echo = q.edg_s[1];
        // oscillator divider freezes in stop
        if (osc_on) begin
            d.div = tick ? 8'h00 : q.div + 8'h01;
        end
        // halted falling edge arms the stop for the next low phase
        if (q.halt_s[2] && !q.halt_s[1]) begin
            d.halt_arm = 1'b1;
        end else if (q.halt_s[1]) begin
            d.halt_arm = 1'b0; // processor left halt: a stale arm would stop a later mode change
        end
        // sequencer
        case (q.st)
            HCC_S_RUN: begin
                d.edge_pend = 1'b0; // edges while clocking go to the processor, not to the next halt
                if (tick) begin
                    d.phase = !q.phase;
                    // stop only where a rising edge was due, so the last low is whole
                    if (toggle && !q.clk && q.halt_arm && q.m1_s[1] && stop_mode) begin
                        d.halt_arm = 1'b0;
                        d.phase = 1'b0;
                        d.st = q.ms1 ? HCC_S_STOP : HCC_S_IDLE;
                    end else if (toggle) begin
                        d.clk = !q.clk;
                    end
                end
            end
            HCC_S_IDLE: begin
                d.clk = 1'b0;
                if (restart_req) begin
                    d.edge_pend = 1'b0;
                    d.resume = 4'h0;
                    d.st = HCC_S_RESUME;
                end
            end
            HCC_S_STOP: begin
                d.clk = 1'b0;
                if (!q.rst_s[1]) begin
                    d.edge_pend = 1'b0;
                    d.st = HCC_S_RUN;
                end else if (restart_req) begin
                    d.edge_pend = 1'b0;
                    d.warm = 19'h0;
                    d.st = HCC_S_WARM;
                end
            end
            HCC_S_WARM: begin
                // reset during warm-up cuts it short
                if (!q.rst_s[1]) begin
                    d.st = HCC_S_RUN;
                end else if (tick) begin
                    d.warm = q.warm + 19'h1;
                    if (q.warm == warm_last(q.wsel)) begin
                        d.st = HCC_S_RUN;
                    end
                end
            end
            HCC_S_RESUME: begin
                if (tick) begin
                    d.resume = q.resume + 4'h1;
                    if (q.resume == `HCC_RESUME_TICKS - 4'h1) begin
                        d.st = HCC_S_RUN;
                    end
                end
            end
            default: begin
                d.st = HCC_S_RUN;
                d.clk = 1'b0;
            end
        endcase
        // set wins over the clear taken above
        if (edge_fall) begin
            d.edge_pend = 1'b1;
        end
        // reset fan-out: low with the pin, then for a few generated clocks
        if (!q.rst_s[1]) begin
            d.rfo = 1'b0;
            d.rfo_cnt = 2'h0;
        end else if (!q.rfo && d.clk && !q.clk) begin
            d.rfo_cnt = q.rfo_cnt + 2'h1;
            if (q.rfo_cnt == `HCC_RESET_HOLD - 2'h1) begin
                d.rfo = 1'b1;
            end
        end
        // axi write: address and data in either order
        if (aw_now) begin
            d.aw_got = 1'b1;
            d.aw_addr = s_axi_awaddr;
            d.awready = 1'b0;
        end
        if (w_now) begin
            d.w_got = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
            d.wready = 1'b0;
        end
        if (q.aw_got && q.w_got && !q.bvalid) begin
            d.bvalid = 1'b1;
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            if (q.aw_addr == `HCC_CTRL_OFFSET) begin
                d.bresp = `HCC_RESP_OKAY;
                if (q.w_strb[0]) begin
                    d.div_sel = q.w_data[`HCC_CTRL_DIV_BIT];
                    d.ms1 = q.w_data[`HCC_CTRL_MS1_BIT];
                    d.ms2 = q.w_data[`HCC_CTRL_MS2_BIT];
                    d.wsel = q.w_data[`HCC_CTRL_WSEL_BIT];
                end
            end else if (q.aw_addr == `HCC_STATUS_OFFSET) begin
                d.bresp = `HCC_RESP_OKAY; // status is read only, write ignored
            end else begin
                d.bresp = `HCC_RESP_SLVERR;
            end
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
            d.awready = 1'b1;
            d.wready = 1'b1;
        end
        // axi read
        if (ar_now) begin
            d.arready = 1'b0;
            d.rvalid = 1'b1;
            d.rresp = `HCC_RESP_OKAY;
            d.rdata = 32'h0;
            if (s_axi_araddr == `HCC_CTRL_OFFSET) begin
                d.rdata[`HCC_CTRL_DIV_BIT] = q.div_sel;
                d.rdata[`HCC_CTRL_MS1_BIT] = q.ms1;
                d.rdata[`HCC_CTRL_MS2_BIT] = q.ms2;
                d.rdata[`HCC_CTRL_WSEL_BIT] = q.wsel;
            end else if (s_axi_araddr == `HCC_STATUS_OFFSET) begin
                d.rdata[4:0] = q.st;
                d.rdata[5] = q.edge_pend;
                d.rdata[6] = q.halt_arm;
                d.rdata[7] = q.rfo;
            end else begin
                d.rresp = `HCC_RESP_SLVERR;
            end
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end
    end

    // single register bank; synchronisers reset to the idle-high pin level
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            q <= '0;
            q.st <= HCC_S_RUN;
            q.halt_s <= 3'h7;
            q.m1_s <= 2'h3;
            q.lvl_s <= 2'h3;
            q.edg_s <= 3'h7;
            q.rst_s <= 2'h3;
            q.rfo <= 1'b1;
            q.echo <= 1'b1;
            q.div_sel <= `HCC_CTRL_DIV_RESET;
            q.ms1 <= `HCC_CTRL_MS1_RESET;
            q.ms2 <= `HCC_CTRL_MS2_RESET;
            q.wsel <= `HCC_CTRL_WSEL_RESET;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the register bank
    assign clk_gen_out = q.clk;
    assign restart_echo_out_n = q.echo;
    assign reset_fanout_out_n = q.rfo;
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_clk_on_tick: assert property ($changed(q.clk) && $past(q.st) == HCC_S_RUN |-> $past(tick))
        else $error("generated clock moved off an oscillator edge");
    a_full_rate: assert property (q.st == HCC_S_RUN && tick && q.div_sel && q.clk |=> !q.clk)
        else $error("full rate clock did not fall on the next half period");
    a_half_rate: assert property (q.st == HCC_S_RUN && tick && !q.div_sel && !q.phase |=> $stable(q.clk))
        else $error("half rate clock moved on a skipped half period");
    a_halt_low: assert property (q.st inside {HCC_S_IDLE, HCC_S_STOP, HCC_S_WARM, HCC_S_RESUME} |-> !q.clk)
        else $error("clock not held low while stopped");
    a_stop_frozen: assert property (q.st == HCC_S_STOP && $past(q.st) == HCC_S_STOP |-> $stable(q.div))
        else $error("oscillator ran in stop mode");
    a_run_no_stop: assert property (q.st == HCC_S_RUN && q.ms1 && q.ms2 |=> q.st == HCC_S_RUN)
        else $error("run mode stopped the clock");
    a_reset_skip: assert property (q.st == HCC_S_STOP && !q.rst_s[1] |=> q.st == HCC_S_RUN)
        else $error("reset restart did not skip warm-up");
    a_warm_entry: assert property (q.st == HCC_S_STOP && q.rst_s[1] && !q.lvl_s[1] |=> q.st == HCC_S_WARM)
        else $error("stop restart did not start warm-up");
    a_idle_resume: assert property (q.st == HCC_S_IDLE && restart_req |=> q.st == HCC_S_RESUME ##1
        q.st == HCC_S_RESUME [*1] ##[0:20] q.st == HCC_S_RUN)
        else $error("idle restart not short");
    a_edge_latch: assert property (edge_fall |=> q.edge_pend || q.st != $past(q.st))
        else $error("edge restart lost");
    a_echo_follow: assert property (q.echo == $past(q.edg_s[1]))
        else $error("echo does not follow edge restart");
    a_fanout_low: assert property (!q.rst_s[1] |=> !q.rfo)
        else $error("reset fan-out not low with reset pin");

    c_halt_idle: cover property (q.st == HCC_S_RUN ##1 q.st == HCC_S_IDLE);
    c_stop_warm: cover property (q.st == HCC_S_WARM ##1 q.st == HCC_S_RUN);
    c_stop_reset: cover property (q.st == HCC_S_STOP && !q.rst_s[1]);

endmodule

// *** hcc_cpu_model.sv ***
/*
 * behavioural processor for the halt clock controller bench: a four-state
 * fetch cycle on the generated clock, halt entry at the fall of T4, and
 * release on reset fan-out, latched echo or an enabled level request.
 * assumes the generated clock and fan-out come from the controller and that
 * the bench drives halt_req_in and interrupt_enable_ff_in.
 */
module hcc_cpu_model (
    // from the controller
    input wire logic clk_gen_in,
    input wire logic reset_fanout_in_n,
    input wire logic restart_echo_in_n,
    input wire logic restart_level_in_n,
    // bench control
    input wire logic halt_req_in,
    input wire logic interrupt_enable_ff_in,
    // status pins to the controller
    output logic halted_out_n,
    output logic opcode_fetch_cycle_out_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] t_q = 2'h0; // t state: 1..3 are T1..T3, 0 is T4
    logic nmi_req_q = 1'b0; // toggles on each echo fall, so each edge is kept
    logic nmi_ack_q = 1'b0; // copies the request when it is taken or reset
    logic halted_q = 1'b1; // halted, active low
    assign halted_out_n = halted_q;
    // t state advances on each rising clock edge
    always @(posedge clk_gen_in) t_q <= t_q + 2'h1;
    // fetch strobe low in T1 and T2 only, so it is high when T4 ends
    assign opcode_fetch_cycle_out_n = ~((t_q == 2'h1) || (t_q == 2'h2));
    // echo falls may come while the clock is stopped, so latch them here
    always @(negedge restart_echo_in_n) nmi_req_q <= ~nmi_req_q;
    // interrupts are only seen on a clock fall, never while the clock is stopped
    always @(negedge clk_gen_in or negedge reset_fanout_in_n) begin
        if (!reset_fanout_in_n) begin
            halted_q <= 1'b1;
            nmi_ack_q <= nmi_req_q;
        end else if (!halted_q && ((nmi_req_q != nmi_ack_q) || (!restart_level_in_n && interrupt_enable_ff_in))) begin
            halted_q <= 1'b1;
            nmi_ack_q <= nmi_req_q;
        end else if (halt_req_in && t_q == 2'h0) begin
            halted_q <= 1'b0;
        end
    end
endmodule

// *** halt_clock_controller_test.sv ***
/*
 * self-checking bench of the halt clock controller: axi4-lite register
 * tasks, clock counting and restart timing in run, idle and stop modes.
 * assumes the processor model drives the halt and fetch pins.
 */
`include "hcc_cfg.svh"

module halt_clock_controller_test;
    timeunit 1ns;
    timeprecision 1ps;
    // shortened counts so warm-up stays in tens of cycles
    localparam int OSC = 2;
    localparam int LONG = 3;
    localparam int SHORT = 2;
    localparam int WL = (2 ** (LONG + 1)) * OSC;
    localparam int WS = (2 ** (SHORT + 1)) * OSC;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic lvl_n = 1'b1, edg_n = 1'b1, sys_n = 1'b1, halt_req = 1'b0, ie = 1'b0;
    logic halted_n, m1_n, clk_gen, echo_n, rfo_n;
    logic [3:0] aw_addr = 4'h0, ar_addr = 4'h0, w_strb = 4'hf;
    logic [31:0] w_data = 32'h0;
    logic aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
    logic [1:0] b_resp, r_resp;
    logic [31:0] r_data;
    int num_errors = 0;
    int checked = 0;
    int n;
    always #4 clk_in = ~clk_in;

    hcc_halt_clock_ctrl #(.OSC_HALF(OSC), .WARM_LONG_LOG2(LONG), .WARM_SHORT_LOG2(SHORT)) dut (
        .clk_in(clk_in), .rst_in(rst_in), .halted_in_n(halted_n), .opcode_fetch_cycle_in_n(m1_n),
        .restart_level_in_n(lvl_n), .restart_edge_in_n(edg_n), .system_reset_in_n(sys_n),
        .clk_gen_out(clk_gen), .restart_echo_out_n(echo_n), .reset_fanout_out_n(rfo_n),
        .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready),
        .s_axi_wdata(w_data), .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready),
        .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid), .s_axi_bready(b_ready),
        .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
        .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid), .s_axi_rready(r_ready));

    hcc_cpu_model cpu (
        .clk_gen_in(clk_gen), .reset_fanout_in_n(rfo_n), .restart_echo_in_n(echo_n),
        .restart_level_in_n(lvl_n), .halt_req_in(halt_req), .interrupt_enable_ff_in(ie),
        .halted_out_n(halted_n), .opcode_fetch_cycle_out_n(m1_n));

    // verdict, reached from the main sequence and from any expired wait
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic hang();
        num_errors++;
        $display("MISMATCH t=%0t wait expired got %h exp %h", $time, 1'b0, 1'b1);
        final_report();
    endtask

    // four-state compare, an unknown never matches
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // cycle counts measured by the bench against a window
    task automatic cmp_range(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h to %h", $time, got, lo, hi);
        end
    endtask

    // write: address and data offered together, bready held until bvalid
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        aw_addr <= a;
        w_data <= d;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_in);
            if (aw_ready) aw_valid <= 1'b0;
            if (w_ready) w_valid <= 1'b0;
            if (b_valid && !aw_valid && !w_valid) break;
        end
        if (i == 50) hang();
        b_ready <= 1'b0;
        cmp({30'h0, b_resp}, {30'h0, er});
        @(posedge clk_in);
    endtask

    // read: rdata and rresp taken at the edge where rvalid is seen
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] ed, input logic [1:0] er);
        int i;
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_in);
            if (ar_ready) ar_valid <= 1'b0;
            if (r_valid && !ar_valid) break;
        end
        if (i == 50) hang();
        r_ready <= 1'b0;
        cmp(r_data & m, ed);
        cmp({30'h0, r_resp}, {30'h0, er});
        @(posedge clk_in);
    endtask

    // rising edges of the generated clock over a fixed window
    task automatic rises(input int cyc, input int exp);
        logic prev;
        int r;
        prev = clk_gen;
        r = 0;
        repeat (cyc) begin
            @(posedge clk_in);
            if (clk_gen && !prev) r++;
            prev = clk_gen;
        end
        cmp_range(r, exp, exp);
    endtask

    // cycles until the generated clock next rises
    task automatic wait_rise(output int c);
        logic prev;
        prev = clk_gen;
        for (c = 1; c < 400; c++) begin
            @(posedge clk_in);
            if (clk_gen && !prev) return;
            prev = clk_gen;
        end
        hang();
    endtask

    // processor halt, then time for the stop to settle
    task automatic do_halt();
        int i;
        halt_req <= 1'b1;
        for (i = 0; i < 100 && halted_n; i++) @(posedge clk_in);
        if (halted_n) hang();
        halt_req <= 1'b0;
        repeat (24) @(posedge clk_in);
    endtask

    initial begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        // register map, refusals and masked write
        axi_rd(`HCC_CTRL_OFFSET, 32'hf, 32'h7, `HCC_RESP_OKAY);
        axi_rd(`HCC_STATUS_OFFSET, 32'h7f, 32'h1, `HCC_RESP_OKAY);
        axi_rd(4'h8, 32'hffffffff, 32'h0, `HCC_RESP_SLVERR);
        axi_wr(4'hc, 32'h0, `HCC_RESP_SLVERR);
        w_strb <= 4'h0;
        axi_wr(`HCC_CTRL_OFFSET, 32'h0, `HCC_RESP_OKAY);
        w_strb <= 4'hf;
        axi_rd(`HCC_CTRL_OFFSET, 32'hf, 32'h7, `HCC_RESP_OKAY);
        // full rate then half rate
        rises(64, 64 / (2 * OSC));
        axi_wr(`HCC_CTRL_OFFSET, 32'h6, `HCC_RESP_OKAY);
        repeat (16) @(posedge clk_in);
        rises(64, 64 / (4 * OSC));
        axi_wr(`HCC_CTRL_OFFSET, 32'h7, `HCC_RESP_OKAY);
        // run mode keeps clocking while halted; short edge pulse releases
        do_halt();
        rises(40, 40 / (2 * OSC));
        edg_n <= 1'b0;
        repeat (2) @(posedge clk_in);
        edg_n <= 1'b1;
        repeat (40) @(posedge clk_in);
        cmp({31'h0, halted_n}, 32'h1);
        // idle mode: stop low, quick level restart, then free running
        axi_wr(`HCC_CTRL_OFFSET, 32'h1, `HCC_RESP_OKAY);
        ie <= 1'b1;
        do_halt();
        rises(40, 0);
        axi_rd(`HCC_STATUS_OFFSET, 32'h1f, 32'h2, `HCC_RESP_OKAY);
        lvl_n <= 1'b0;
        wait_rise(n);
        cmp_range(n, 5 * OSC, 5 * OSC + 12);
        repeat (8) @(posedge clk_in);
        lvl_n <= 1'b1;
        repeat (16) @(posedge clk_in);
        cmp({31'h0, halted_n}, 32'h1);
        rises(40, 40 / (2 * OSC));
        // stop mode, long warm-up through the edge restart
        axi_wr(`HCC_CTRL_OFFSET, 32'h3, `HCC_RESP_OKAY);
        do_halt();
        rises(40, 0);
        axi_rd(`HCC_STATUS_OFFSET, 32'h1f, 32'h4, `HCC_RESP_OKAY);
        edg_n <= 1'b0;
        repeat (5) @(posedge clk_in);
        cmp({31'h0, echo_n}, 32'h0);
        edg_n <= 1'b1;
        wait_rise(n);
        cmp_range(n + 5, WL, WL + 12);
        repeat (16) @(posedge clk_in);
        // stop mode, short warm-up through the level restart
        axi_wr(`HCC_CTRL_OFFSET, 32'hb, `HCC_RESP_OKAY);
        do_halt();
        lvl_n <= 1'b0;
        wait_rise(n);
        cmp_range(n, WS, WS + 12);
        repeat (8) @(posedge clk_in);
        lvl_n <= 1'b1;
        repeat (16) @(posedge clk_in);
        // stop mode, reset pin restarts at once and drives the fan-out
        axi_wr(`HCC_CTRL_OFFSET, 32'h3, `HCC_RESP_OKAY);
        do_halt();
        sys_n <= 1'b0;
        wait_rise(n);
        cmp_range(n, 1, 8);
        repeat (12) @(posedge clk_in);
        cmp({31'h0, rfo_n}, 32'h0);
        sys_n <= 1'b1;
        repeat (2) @(posedge clk_in);
        cmp({31'h0, rfo_n}, 32'h0);
        repeat (40) @(posedge clk_in);
        cmp({31'h0, rfo_n}, 32'h1);
        cmp({31'h0, halted_n}, 32'h1);
        final_report();
    end
endmodule
